// file: flash_segment_code_protect.sv
// Flash boot and secure segment code protection with APB configuration access
//
// Functional notes
// - Boot writes allowed only when boot_write_protect set
// - Boot size x11 means no boot segment
// - Boot size 110/010: 1K words, ends 0x0007FE
// - Boot size 101/001: 4K words, ends 0x001FFE
// - Boot size 100/000: 8K words, ends 0x003FFE
// - Boot RAM size: none, 128, 256, 1024 bytes
// - Secure writes allowed only when secure_write_protect set
// - Secure size X11 means no secure segment
// - Secure 110/010: boot end to 0x001FFE
// - Secure 101/001: boot end to 0x003FFE
// - Secure 100/000: boot end to 0x007FFE
// - Small variants have no secure segment
// - Configuration changes take effect immediately
`timescale 1ns/1ps
module flash_segment_code_protect
	import seg_protect_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic small_variant,
	input wire logic flash_wr_valid,
	input wire logic [ADDR_W-1:0] flash_wr_addr,
	output logic flash_wr_go,
	output logic flash_wr_blocked,
	output logic [ADDR_W-1:0] flash_wr_addr_out,
	output logic [10:0] boot_ram_bytes,
	output logic boot_high_security,
	output logic secure_high_security
);

	// True when addr lies within [lo, hi]
	function automatic logic in_range(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		in_range = (addr >= lo) && (addr <= hi);
	endfunction

	// Boot configuration: write protect, boot size, boot RAM size
	logic boot_write_protect;
	logic [2:0] boot_segment_size;
	logic [1:0] boot_ram_size;
	// Secure configuration: write protect, secure size
	logic secure_write_protect;
	logic [2:0] secure_segment_size;
	// Two-stage synchroniser for the variant strap pin
	logic variant_meta;
	logic variant_sync;
	// Sticky flag and address of the last suppressed write
	logic blocked_flag;
	logic [ADDR_W-1:0] blocked_addr;
	// Decoded segment map
	seg_map_s seg_map;

	// APB phase decode
	wire logic apb_setup;
	wire logic apb_commit;
	wire logic apb_wr;
	// Address decode of the mapped registers
	wire logic hit_boot_cfg;
	wire logic hit_sec_cfg;
	wire logic hit_boot_map;
	wire logic hit_sec_map;
	wire logic hit_block;
	wire logic addr_mapped;
	// Read data mux
	wire logic [31:0] next_prdata;
	// Segment membership of the incoming flash write
	wire logic in_boot;
	wire logic in_sec;
	wire logic wr_denied;
	// Clear request for the sticky blocked flag
	wire logic blocked_clear;

	// Setup cycle: answer is prepared for the following access cycle
	assign apb_setup = psel && !penable && !pready;
	// Access completes at the edge where pready is seen high
	assign apb_commit = psel && penable && pready;
	assign apb_wr = apb_commit && pwrite;

	assign hit_boot_cfg = paddr == OFS_BOOT_CFG;
	assign hit_sec_cfg = paddr == OFS_SEC_CFG;
	assign hit_boot_map = paddr == OFS_BOOT_MAP;
	assign hit_sec_map = paddr == OFS_SEC_MAP;
	assign hit_block = paddr == OFS_BLOCK_STAT;
	assign addr_mapped = hit_boot_cfg || hit_sec_cfg || hit_boot_map || hit_sec_map
		|| hit_block;

	// Read values; unused bits read as zero
	assign next_prdata = hit_boot_cfg ? {26'h0000000, boot_ram_size, boot_segment_size,
			boot_write_protect} :
		hit_sec_cfg ? {28'h0000000, secure_segment_size, secure_write_protect} :
		hit_boot_map ? {6'h00, seg_map.boot_valid, seg_map.boot_high, seg_map.boot_end} :
		hit_sec_map ? {6'h00, seg_map.sec_valid, seg_map.sec_high, seg_map.sec_end} :
		hit_block ? {blocked_flag, 7'h00, blocked_addr} : 32'h00000000;

	// Decoder of the live configuration; no reset needed to apply a change
	seg_decode u_decode (
		.boot_segment_size(boot_segment_size),
		.boot_ram_size(boot_ram_size),
		.secure_segment_size(secure_segment_size),
		.secure_present(!variant_sync),
		.seg_map(seg_map)
	);

	// Which protected region does the write land in
	assign in_boot = seg_map.boot_valid && in_range(flash_wr_addr, BOOT_START,
		seg_map.boot_end);
	assign in_sec = seg_map.sec_valid && in_range(flash_wr_addr, seg_map.sec_start,
		seg_map.sec_end);
	// Deny on a cleared protect bit of the segment hit
	assign wr_denied = (in_boot && !boot_write_protect)
		|| (in_sec && !secure_write_protect);

	// Software clears the sticky flag by writing one to its bit
	assign blocked_clear = apb_wr && hit_block && pwdata[BLK_FLAG_BIT];

	// APB handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			// Single wait-free access cycle after every setup
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_mapped;
			prdata <= apb_setup ? next_prdata : 32'h00000000;
		end
	end

	// Boot configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{boot_ram_size, boot_segment_size, boot_write_protect} <= BOOT_CFG_RST;
		end else if (apb_wr && hit_boot_cfg) begin
			// New settings steer the decoder on the next cycle
			boot_write_protect <= pwdata[BWP_BIT];
			boot_segment_size <= pwdata[BOOT_SIZE_LSB +: 3];
			boot_ram_size <= pwdata[RAM_SIZE_LSB +: 2];
		end
	end

	// Secure configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{secure_segment_size, secure_write_protect} <= SEC_CFG_RST;
		end else if (apb_wr && hit_sec_cfg) begin
			secure_write_protect <= pwdata[SWP_BIT];
			secure_segment_size <= pwdata[SEC_SIZE_LSB +: 3];
		end
	end

	// Variant strap synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			variant_meta <= 1'b0;
			variant_sync <= 1'b0;
		end else begin
			variant_meta <= small_variant;
			variant_sync <= variant_meta;
		end
	end

	// Flash write gate: pass or suppress, one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_wr_go <= 1'b0;
			flash_wr_blocked <= 1'b0;
			flash_wr_addr_out <= '0;
		end else begin
			flash_wr_go <= flash_wr_valid && !wr_denied;
			flash_wr_blocked <= flash_wr_valid && wr_denied;
			flash_wr_addr_out <= flash_wr_addr;
		end
	end

	// Sticky blocked record; a new block wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blocked_flag <= 1'b0;
			blocked_addr <= '0;
		end else begin
			if (flash_wr_valid && wr_denied) begin
				blocked_flag <= 1'b1;
				blocked_addr <= flash_wr_addr;
			end else if (blocked_clear) begin
				blocked_flag <= 1'b0;
			end
		end
	end

	// Registered view of the decoded map for the rest of the chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_ram_bytes <= RAM_NONE;
			boot_high_security <= 1'b0;
			secure_high_security <= 1'b0;
		end else begin
			boot_ram_bytes <= seg_map.ram_bytes;
			boot_high_security <= seg_map.boot_high;
			secure_high_security <= seg_map.sec_high;
		end
	end

	// Checks

	// Write committed to the boot configuration register
	sequence boot_cfg_write;
		apb_wr && hit_boot_cfg;
	endsequence

	// A write landing in the boot segment
	sequence boot_hit_wr;
		flash_wr_valid && in_boot && !in_sec;
	endsequence

	chk_boot_wp_block: assert property (@(posedge pclk) disable iff (!presetn)
		boot_hit_wr and (!boot_write_protect) |=> flash_wr_blocked && !flash_wr_go)
		else $error("boot write passed while protected");

	chk_boot_wr_pass: assert property (@(posedge pclk) disable iff (!presetn)
		boot_hit_wr and boot_write_protect |=> flash_wr_go && !flash_wr_blocked)
		else $error("boot write blocked while writable");

	chk_boot_none: assert property (@(posedge pclk) disable iff (!presetn)
		boot_segment_size[1:0] == 2'h3 |-> !seg_map.boot_valid && !in_boot)
		else $error("boot segment defined for x11");

	chk_boot_sizes: assert property (@(posedge pclk) disable iff (!presetn)
		(boot_segment_size[1:0] == 2'h2 |-> seg_map.boot_end == 24'h0007fe)
		and (boot_segment_size[1:0] == 2'h1 |-> seg_map.boot_end == 24'h001ffe)
		and (boot_segment_size[1:0] == 2'h0 |-> seg_map.boot_end == 24'h003ffe))
		else $error("boot segment end wrong");

	chk_ram_size: assert property (@(posedge pclk) disable iff (!presetn)
		##1 boot_ram_bytes == ($past(boot_ram_size) == 2'h3 ? 11'h000 :
			$past(boot_ram_size) == 2'h2 ? 11'h080 :
			$past(boot_ram_size) == 2'h1 ? 11'h100 : 11'h400))
		else $error("boot RAM size wrong");

	chk_sec_wp_block: assert property (@(posedge pclk) disable iff (!presetn)
		flash_wr_valid && in_sec && !secure_write_protect |=> flash_wr_blocked)
		else $error("secure write passed while protected");

	chk_sec_none: assert property (@(posedge pclk) disable iff (!presetn)
		(secure_segment_size[1:0] == 2'h3 || variant_sync) |-> !seg_map.sec_valid)
		else $error("secure segment defined when absent");

	chk_sec_ends: assert property (@(posedge pclk) disable iff (!presetn)
		seg_map.sec_valid |-> seg_map.sec_start == (seg_map.boot_valid ?
			seg_map.boot_end + 24'h000002 : 24'h000200)
		&& ((secure_segment_size[1:0] == 2'h2 && seg_map.sec_end == 24'h001ffe)
		|| (secure_segment_size[1:0] == 2'h1 && seg_map.sec_end == 24'h003ffe)
		|| (secure_segment_size[1:0] == 2'h0 && seg_map.sec_end == 24'h007ffe)))
		else $error("secure segment bounds wrong");

	chk_cfg_immediate: assert property (@(posedge pclk) disable iff (!presetn)
		boot_cfg_write |=> boot_segment_size == $past(pwdata[3:1])
		&& boot_write_protect == $past(pwdata[0]))
		else $error("boot config change not applied at once");

	chk_unprotected_go: assert property (@(posedge pclk) disable iff (!presetn)
		flash_wr_valid && !in_boot && !in_sec |=> flash_wr_go && !flash_wr_blocked)
		else $error("write outside segments not passed");

	chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");

	// A denied flash write request
	sequence denied_wr;
		flash_wr_valid && wr_denied;
	endsequence

	// A write landing in the secure segment
	sequence sec_hit_wr;
		flash_wr_valid && in_sec && !in_boot;
	endsequence

	// Write committed to the secure configuration register
	sequence sec_cfg_write;
		apb_wr && hit_sec_cfg;
	endsequence

	chk_sec_wr_pass: assert property (@(posedge pclk) disable iff (!presetn)
		sec_hit_wr and secure_write_protect |=> flash_wr_go && !flash_wr_blocked)
		else $error("secure write blocked while writable");

	chk_sec_wp_gate: assert property (@(posedge pclk) disable iff (!presetn)
		sec_hit_wr and (!secure_write_protect) |=> !flash_wr_go)
		else $error("secure write let through while protected");

	chk_flag_record: assert property (@(posedge pclk) disable iff (!presetn)
		denied_wr |=> blocked_flag && blocked_addr == $past(flash_wr_addr))
		else $error("blocked write not recorded");

	chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		blocked_clear && !(flash_wr_valid && wr_denied) |=> !blocked_flag)
		else $error("blocked flag not cleared");

	chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(flash_wr_valid && wr_denied) && !blocked_clear
		|=> $stable(blocked_flag) && $stable(blocked_addr))
		else $error("blocked record changed without cause");

	chk_gate_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!flash_wr_valid |=> !flash_wr_go && !flash_wr_blocked)
		else $error("flash verdict without a request");

	chk_addr_copy: assert property (@(posedge pclk) disable iff (!presetn)
		flash_wr_valid |=> flash_wr_addr_out == $past(flash_wr_addr))
		else $error("flash address copy wrong");

	chk_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pready && !addr_mapped
		|=> pready && pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	chk_apb_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> !pslverr && prdata == 32'h00000000)
		else $error("APB outputs not quiet between accesses");

	chk_sec_cfg_apply: assert property (@(posedge pclk) disable iff (!presetn)
		sec_cfg_write |=> secure_segment_size == $past(pwdata[SEC_SIZE_LSB +: 3])
		&& secure_write_protect == $past(pwdata[SWP_BIT]))
		else $error("secure config change not applied at once");

	chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(apb_wr && (hit_boot_cfg || hit_sec_cfg)) |=> $stable(boot_segment_size)
		&& $stable(boot_write_protect) && $stable(boot_ram_size)
		&& $stable(secure_segment_size) && $stable(secure_write_protect))
		else $error("configuration changed without a write");

	chk_high_flags: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> boot_high_security == $past(seg_map.boot_high)
		&& secure_high_security == $past(seg_map.sec_high))
		else $error("security level outputs wrong");

	chk_sec_after_boot: assert property (@(posedge pclk) disable iff (!presetn)
		seg_map.sec_valid && seg_map.boot_valid |-> seg_map.sec_start > seg_map.boot_end)
		else $error("secure segment overlaps boot segment");

endmodule // flash_segment_code_protect

// file: seg_protect_pkg.sv
// Shared constants and types for the flash segment code-protection block
package seg_protect_pkg;

	// Program address width (instruction-word addressing, even addresses)
	localparam int ADDR_W = 24;

	// Register byte offsets on the APB side
	localparam logic [7:0] OFS_BOOT_CFG = 8'h00;
	localparam logic [7:0] OFS_SEC_CFG = 8'h04;
	localparam logic [7:0] OFS_BOOT_MAP = 8'h08;
	localparam logic [7:0] OFS_SEC_MAP = 8'h0c;
	localparam logic [7:0] OFS_BLOCK_STAT = 8'h10;

	// Field positions in the boot segment configuration register
	localparam int BWP_BIT = 0;
	localparam int BOOT_SIZE_LSB = 1;
	localparam int RAM_SIZE_LSB = 4;
	// Field positions in the secure segment configuration register
	localparam int SWP_BIT = 0;
	localparam int SEC_SIZE_LSB = 1;
	// Sticky blocked flag position in the block status register
	localparam int BLK_FLAG_BIT = 31;

	// Erased configuration: no segments, everything writable
	localparam logic [5:0] BOOT_CFG_RST = 6'h3f;
	localparam logic [3:0] SEC_CFG_RST = 4'hf;

	// Low two bits of a size field: "no segment", then small, mid and large
	localparam logic [1:0] SIZE_NONE = 2'h3;
	localparam logic [1:0] SIZE_SMALL = 2'h2;
	localparam logic [1:0] SIZE_MID = 2'h1;
	localparam logic [1:0] SIZE_LARGE = 2'h0;

	// First address above the interrupt vectors
	localparam logic [ADDR_W-1:0] BOOT_START = 24'h000200;
	// Boot segment end addresses
	localparam logic [ADDR_W-1:0] BOOT_END_1K = 24'h0007fe;
	localparam logic [ADDR_W-1:0] BOOT_END_4K = 24'h001ffe;
	localparam logic [ADDR_W-1:0] BOOT_END_8K = 24'h003ffe;
	// Secure segment end addresses
	localparam logic [ADDR_W-1:0] SEC_END_4K = 24'h001ffe;
	localparam logic [ADDR_W-1:0] SEC_END_8K = 24'h003ffe;
	localparam logic [ADDR_W-1:0] SEC_END_16K = 24'h007ffe;
	// Step from one instruction word to the next
	localparam logic [ADDR_W-1:0] WORD_STEP = 24'h000002;

	// Boot RAM sizes in bytes
	localparam logic [10:0] RAM_NONE = 11'h000;
	localparam logic [10:0] RAM_128 = 11'h080;
	localparam logic [10:0] RAM_256 = 11'h100;
	localparam logic [10:0] RAM_1024 = 11'h400;

	// Decoded segment map
	typedef struct packed {
		logic boot_valid;
		logic boot_high;
		logic [ADDR_W-1:0] boot_end;
		logic sec_valid;
		logic sec_high;
		logic [ADDR_W-1:0] sec_start;
		logic [ADDR_W-1:0] sec_end;
		logic [10:0] ram_bytes;
	} seg_map_s;

endpackage

// file: seg_decode.sv
// Combinational decoder from configuration fields to the segment map
`timescale 1ns/1ps
module seg_decode
	import seg_protect_pkg::*;
(
	input wire logic [2:0] boot_segment_size,
	input wire logic [1:0] boot_ram_size,
	input wire logic [2:0] secure_segment_size,
	input wire logic secure_present,
	output seg_map_s seg_map
);

	// Boot end address per size code
	wire logic [ADDR_W-1:0] boot_end;
	// Secure end address per size code
	wire logic [ADDR_W-1:0] sec_end;
	// Secure start follows the boot segment, or the vectors if none
	wire logic [ADDR_W-1:0] sec_start;
	wire logic boot_valid;
	wire logic sec_valid;

	assign boot_valid = boot_segment_size[1:0] != SIZE_NONE;
	assign boot_end = (boot_segment_size[1:0] == SIZE_SMALL) ? BOOT_END_1K :
		(boot_segment_size[1:0] == SIZE_MID) ? BOOT_END_4K :
		(boot_segment_size[1:0] == SIZE_LARGE) ? BOOT_END_8K : BOOT_START;

	assign sec_end = (secure_segment_size[1:0] == SIZE_SMALL) ? SEC_END_4K :
		(secure_segment_size[1:0] == SIZE_MID) ? SEC_END_8K :
		(secure_segment_size[1:0] == SIZE_LARGE) ? SEC_END_16K : BOOT_START;
	assign sec_start = boot_valid ? (boot_end + WORD_STEP) : BOOT_START;
	// Absent on small variants, and empty when the boot segment covers it
	assign sec_valid = secure_present && (secure_segment_size[1:0] != SIZE_NONE)
		&& (sec_end >= sec_start);

	// Pack the map; bit 2 clear means high security
	assign seg_map.boot_valid = boot_valid;
	assign seg_map.boot_high = boot_valid && !boot_segment_size[2];
	assign seg_map.boot_end = boot_end;
	assign seg_map.sec_valid = sec_valid;
	assign seg_map.sec_high = sec_valid && !secure_segment_size[2];
	assign seg_map.sec_start = sec_start;
	assign seg_map.sec_end = sec_end;
	assign seg_map.ram_bytes = (boot_ram_size == SIZE_SMALL) ? RAM_128 :
		(boot_ram_size == SIZE_MID) ? RAM_256 :
		(boot_ram_size == SIZE_LARGE) ? RAM_1024 : RAM_NONE;

endmodule // seg_decode

// file: tb_top.sv
// Self-checking testbench for the flash segment code-protection block
`timescale 1ns/1ps
module tb_top;
	import seg_protect_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, small_variant, flash_wr_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [ADDR_W-1:0] flash_wr_addr, flash_wr_addr_out;
	logic [10:0] boot_ram_bytes;
	logic pready, pslverr, flash_wr_go, flash_wr_blocked, er;
	logic boot_high_security, secure_high_security;
	logic [2:0] b; // Size code under test
	logic v; // Expected segment present
	int err_total = 0;
	int cmp_count = 0;

	flash_segment_code_protect dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.small_variant(small_variant), .flash_wr_valid(flash_wr_valid),
		.flash_wr_addr(flash_wr_addr), .flash_wr_go(flash_wr_go),
		.flash_wr_blocked(flash_wr_blocked), .flash_wr_addr_out(flash_wr_addr_out),
		.boot_ram_bytes(boot_ram_bytes), .boot_high_security(boot_high_security),
		.secure_high_security(secure_high_security));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Expected boot segment end for a size code
	function automatic logic [23:0] bend(input logic [2:0] s);
		case (s[1:0])
			2'h2: return 24'h0007fe;
			2'h1: return 24'h001ffe;
			2'h0: return 24'h003ffe;
			default: return 24'h000000;
		endcase
	endfunction

	// Expected secure segment end for a size code
	function automatic logic [23:0] send(input logic [2:0] s);
		case (s[1:0])
			2'h2: return 24'h001ffe;
			2'h1: return 24'h003ffe;
			2'h0: return 24'h007ffe;
			default: return 24'h000000;
		endcase
	endfunction

	// Expected boot RAM bytes for a size code
	function automatic logic [10:0] ram(input logic [1:0] s);
		case (s)
			2'h2: return 11'h080;
			2'h1: return 11'h100;
			2'h0: return 11'h400;
			default: return 11'h000;
		endcase
	endfunction

	// Compare one value and count the result
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; setup, then access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 20) begin
			err_total++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	// Register read compared under a mask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, er);
		chk("prdata", exp, rd & m);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask

	// One flash write request and its one-cycle verdict
	task automatic fw(input logic [23:0] a, input logic go);
		@(posedge pclk);
		flash_wr_valid <= 1'b1;
		flash_wr_addr <= a;
		@(posedge pclk);
		flash_wr_valid <= 1'b0;
		@(posedge pclk);
		chk("flash_wr_go", {31'h0, go}, {31'h0, flash_wr_go});
		chk("flash_wr_blocked", {31'h0, !go}, {31'h0, flash_wr_blocked});
		chk("flash_wr_addr_out", {8'h0, a}, {8'h0, flash_wr_addr_out});
	endtask

	// Print counts and verdict, then stop
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		end_of_test();
	end

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		small_variant = 1'b0;
		flash_wr_valid = 1'b0;
		flash_wr_addr = 24'h000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Erased configuration after reset
		rdc(OFS_BOOT_CFG, 32'hffffffff, 32'h3f);
		rdc(OFS_SEC_CFG, 32'hffffffff, 32'hf);
		rdc(OFS_BOOT_MAP, 32'h02000000, 32'h0);
		// Unmapped address answers with an error
		apb(1'b1, 8'h14, 32'h0, rd, er);
		chk("pslverr", 32'h1, {31'h0, er});
		// Every boot size code, boot RAM field stepped alongside
		for (int s = 0; s < 8; s++) begin
			b = s[2:0];
			v = (b[1:0] != 2'h3);
			wr(OFS_BOOT_CFG, {26'h0, b[1:0], b, 1'b1});
			rdc(OFS_BOOT_MAP, v ? 32'h03ffffff : 32'h03000000,
				{6'h0, v, v & !b[2], bend(b)});
			chk("boot_high", {31'h0, v & !b[2]}, {31'h0, boot_high_security});
			chk("boot_ram_bytes", {21'h0, ram(b[1:0])}, {21'h0, boot_ram_bytes});
		end
		// Every secure size code with no boot segment
		wr(OFS_BOOT_CFG, 32'h3f);
		for (int s = 0; s < 8; s++) begin
			b = s[2:0];
			v = (b[1:0] != 2'h3);
			wr(OFS_SEC_CFG, {28'h0, b, 1'b1});
			rdc(OFS_SEC_MAP, v ? 32'h03ffffff : 32'h03000000,
				{6'h0, v, v & !b[2], send(b)});
			chk("sec_high", {31'h0, v & !b[2]}, {31'h0, secure_high_security});
		end
		// Boot 1K and secure to 4K, both write-protected
		wr(OFS_BOOT_CFG, 32'h3c);
		wr(OFS_SEC_CFG, 32'hc);
		fw(24'h0001fe, 1'b1);
		fw(24'h000200, 1'b0);
		fw(24'h0007fe, 1'b0);
		fw(24'h000800, 1'b0);
		fw(24'h001ffe, 1'b0);
		fw(24'h002000, 1'b1);
		// Read-only map ignores a write
		wr(OFS_SEC_MAP, 32'h0);
		rdc(OFS_SEC_MAP, 32'h03ffffff, 32'h02001ffe);
		// Sticky blocked flag holds the last blocked address, then clears
		rdc(OFS_BLOCK_STAT, 32'h80ffffff, 32'h80001ffe);
		wr(OFS_BLOCK_STAT, 32'h80000000);
		rdc(OFS_BLOCK_STAT, 32'h80000000, 32'h0);
		// Lifting protection acts at once
		wr(OFS_BOOT_CFG, 32'h3d);
		fw(24'h000200, 1'b1);
		wr(OFS_SEC_CFG, 32'hd);
		fw(24'h000800, 1'b1);
		// Boot 4K writable, secure to 16K protected
		wr(OFS_BOOT_CFG, 32'h3b);
		wr(OFS_SEC_CFG, 32'h8);
		fw(24'h001ffe, 1'b1);
		fw(24'h002000, 1'b0);
		fw(24'h007ffe, 1'b0);
		fw(24'h008000, 1'b1);
		// No boot segment, secure to 8K protected
		wr(OFS_BOOT_CFG, 32'h3f);
		wr(OFS_SEC_CFG, 32'ha);
		fw(24'h000200, 1'b0);
		fw(24'h003ffe, 1'b0);
		fw(24'h004000, 1'b1);
		// Boot 8K covers secure to 4K: no secure segment is left
		wr(OFS_BOOT_CFG, 32'h39);
		wr(OFS_SEC_CFG, 32'hc);
		rdc(OFS_SEC_MAP, 32'h02000000, 32'h0);
		fw(24'h001ffe, 1'b1);
		// Small part, with the secure segment already emptied by boot 8K: secure map stays invalid
		small_variant <= 1'b1;
		repeat (3) @(posedge pclk);
		fw(24'h000200, 1'b1);
		rdc(OFS_SEC_MAP, 32'h02000000, 32'h0);
		small_variant <= 1'b0;
		end_of_test();
	end
endmodule // tb_top
